/* File: smc_engine.sv */
`default_nettype none
//
// Summary of operation
// - Fixed opcodes select read, program, clear, sleep
// - Bits travel MSB first from first edge
// - Status: busy bit zero, latch bit one
// - Latch clears after completed write-type commands
// - Quick read: opcode, address, dummy, data
// - Only twelve low address bits decoded
// - Read address increments and wraps at top
// - Program starts when select rises cleanly
// - Busy device ignores all but status
// - Busy flag set during program cycle
// - Program column increments within page only
// - Over 32 bytes: last 32 kept
// - Under 32 bytes: others untouched
// - Program completion clears the latch
// - Unarmed program ignored until select rises
// - Page clear fills addressed page with ones
// - Two opcodes both start full clear
// - Busy flag covers clear cycles too
// - Sleep entered when select rises
// - Sleeping device ignores all but wake
// - Wake starts at eighth opcode edge
// - Read and write wait wake delay
//
module smc_engine #(
    parameter int WAKE_CYCLES = smc_pkg::WAKE_CYCLES
) (
    // System clock and reset
    input wire logic sysClk,
    input wire logic resetN,
    // Serial link pins
    input wire logic shiftClock,
    input wire logic selectN,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    // Status levels
    output logic busyFlag,
    output logic enableLatch,
    output logic sleeping
);
    import smc_pkg::*;

    // -----------------------------------------------------------------
    // Link domain
    // -----------------------------------------------------------------

    // Per-frame state, cleared while select is high
    typedef struct packed {
        logic [2:0] bitCnt;
        logic [7:0] inSh;
        logic [7:0] outSh;
    } smc_lframe_t;
    // State that must survive between frames
    typedef struct packed {
        logic [7:0] rxByte;
        logic byteTog;
        logic midByte;
    } smc_lkeep_t;

    smc_lframe_t lf, next_lf;
    smc_lkeep_t lk, next_lk;
    logic frameIdle; // Asynchronous clear of frame state
    logic [7:0] holdByte; // Next outgoing byte, from system side

    assign frameIdle = selectN | ~resetN;

    // Shift in, count bits, hand completed bytes over
    always_comb begin
        next_lf = lf;
        next_lk = lk;
        next_lf.bitCnt = lf.bitCnt + BIT_STEP;
        next_lf.inSh = {lf.inSh[6:0], serialIn};
        next_lf.outSh = {lf.outSh[6:0], 1'b0};
        next_lk.midByte = (lf.bitCnt != BIT_LAST);
        if (lf.bitCnt == BIT_LAST) begin
            // Byte boundary: hand over and reload output
            next_lk.rxByte = {lf.inSh[6:0], serialIn};
            next_lk.byteTog = ~lk.byteTog;
            next_lf.outSh = holdByte;
        end
    end

    // Frame state restarts on every select fall
    always_ff @(posedge shiftClock or posedge frameIdle) begin
        if (frameIdle) begin
            lf <= '0;
        end else begin
            lf <= next_lf;
        end
    end

    // A toggle must never be reset by select, or events would be faked
    always_ff @(posedge shiftClock or negedge resetN) begin
        if (!resetN) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // Output changes after the falling edge only
    always_ff @(negedge shiftClock or posedge frameIdle) begin
        if (frameIdle) begin
            serialOut <= 1'b0;
        end else begin
            serialOut <= lf.outSh[7];
        end
    end

    // Pin is driven only while selected
    assign serialOutEn = ~selectN;

    // -----------------------------------------------------------------
    // Crossing into the system domain
    // -----------------------------------------------------------------

    logic [2:0] syncMid; // Second stages
    logic [2:0] syncOut; // Third stages

    smc_sync3 u_sync (
        .sysClk(sysClk),
        .resetN(resetN),
        .asyncIn({lk.midByte, lk.byteTog, selectN}),
        .syncMid(syncMid),
        .syncOut(syncOut)
    );

    // -----------------------------------------------------------------
    // System domain
    // -----------------------------------------------------------------

    typedef struct packed {
        smc_frame_t st; // Frame decoder
        logic [7:0] cmd; // Opcode of this frame
        logic [ADDR_W-1:0] addr; // Captured address
        logic [ADDR_W-1:0] rdAddr; // Read pointer
        logic [1:0] fetch; // Read pipeline
        logic [7:0] hold; // Byte offered to the link
        logic selHigh; // Settled select level
        logic togSeen; // Settled byte toggle
        logic latch; // Write enable latch
        logic sleep; // Low-power mode
        logic [WAKE_CNT_W-1:0] wakeCnt; // Wake delay left
        smc_op_t op; // Running array operation
        logic [ADDR_W-1:0] opIdx; // Operation pointer
        logic [PAGE_W-1:0] col; // Page column
        logic gotData; // Whole data byte seen
        logic [PAGE_BYTES-1:0] mask; // Columns to write
        logic [PAGE_BYTES-1:0][7:0] pbuf; // Page buffer
    } smc_sys_t;

    smc_sys_t s, n;
    logic byteEv; // One completed byte
    logic frameEnd; // Settled select rise
    logic midAbort; // Select rose inside a byte
    logic [7:0] rxByte; // Byte held stable by the link
    logic [7:0] status; // Status byte
    logic [7:0] rdData; // Array read data
    logic arm_cmd;
    logic [7:0] wrData;
    logic idleOk; // Free for read and write commands
    logic opDone; // Last step of an operation

    // A toggle counts once stages two and three agree on a new level
    assign byteEv = (syncMid[1] == syncOut[1]) && (syncOut[1] != s.togSeen);
    assign frameEnd = (syncMid[0] == syncOut[0]) && syncOut[0] && !s.selHigh;
    assign midAbort = syncOut[2];
    assign rxByte = lk.rxByte; // Stable for a whole byte after the toggle
    assign idleOk = (s.op == OP_NONE) && (s.wakeCnt == '0);
    assign opDone = (s.op == OP_CHIP) ? (s.opIdx == ADDR_LAST) : (s.opIdx[PAGE_W-1:0] == COL_LAST);

    // Status byte; reserved bits stay zero
    always_comb begin
        status = STATUS_ZERO;
        status[STAT_BUSY_BIT] = (s.op != OP_NONE);
        status[STAT_LATCH_BIT] = s.latch;
    end

    // Array write port follows the operation pointer
    always_comb begin
        arm_cmd = 1'b0;
        wrData = ERASED_BYTE;
        if (s.op == OP_PROG) begin
            arm_cmd = s.mask[s.opIdx[PAGE_W-1:0]];
            wrData = s.pbuf[s.opIdx[PAGE_W-1:0]];
        end else if (s.op != OP_NONE) begin
            arm_cmd = 1'b1;
        end
    end

    smc_mem u_mem (
        .sysClk(sysClk),
        .arm_cmd(arm_cmd),
        .wrAddr(s.opIdx),
        .wrData(wrData),
        .rdAddr(s.rdAddr),
        .rdData(rdData)
    );

    // Decoder, read prefetch, wake timer and array sequencer
    always_comb begin
        n = s;
        n.fetch = {s.fetch[0], 1'b0};
        if (syncMid[0] == syncOut[0]) begin
            n.selHigh = syncOut[0];
        end
        if (syncMid[1] == syncOut[1]) begin
            n.togSeen = syncOut[1];
        end
        if (s.wakeCnt != '0) begin
            n.wakeCnt = s.wakeCnt - WAKE_ONE;
        end
        // One array byte per clock while busy
        if (s.op != OP_NONE) begin
            n.opIdx = s.opIdx + ADDR_STEP;
            if (opDone) begin
                n.op = OP_NONE;
                n.latch = 1'b0;
            end
        end
        // Completed byte from the link
        if (byteEv) begin
            case (s.st)
                ST_OPCODE: begin
                    n.cmd = rxByte;
                    n.st = ST_SKIP;
                    if (s.sleep) begin
                        // Only wake is heard while asleep
                        if (rxByte == CMD_WAKE) begin
                            n.sleep = 1'b0;
                            n.wakeCnt = WAKE_CNT_W'(WAKE_CYCLES);
                        end
                    end else if (rxByte == CMD_FLAG_READ) begin
                        n.st = ST_HOLD;
                    end else if (idleOk) begin
                        case (rxByte)
                            CMD_QUICK_READ: n.st = ST_ADDR_HI;
                            CMD_PROGRAM, CMD_PAGE_CLEAR: begin
                                n.st = s.latch ? ST_ADDR_HI : ST_SKIP;
                            end
                            CMD_FULL_CLEAR_A, CMD_FULL_CLEAR_B: begin
                                n.st = s.latch ? ST_HOLD : ST_SKIP;
                            end
                            CMD_ARM, CMD_DISARM, CMD_SLEEP: n.st = ST_HOLD;
                            default: n.st = ST_SKIP;
                        endcase
                    end
                end
                ST_ADDR_HI: begin
                    // Upper four bits of the high byte are not decoded
                    n.addr[ADDR_W-1:8] = rxByte[ADDR_HI_W-1:0];
                    n.st = ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    n.addr[7:0] = rxByte;
                    n.col = rxByte[PAGE_W-1:0];
                    if (s.cmd == CMD_QUICK_READ) begin
                        n.rdAddr = {s.addr[ADDR_W-1:8], rxByte};
                        n.fetch[0] = 1'b1;
                        n.st = ST_DUMMY;
                    end else if (s.cmd == CMD_PROGRAM) begin
                        n.mask = '0;
                        n.gotData = 1'b0;
                        n.st = ST_DATA;
                    end else begin
                        n.st = ST_HOLD;
                    end
                end
                ST_DUMMY, ST_READ: begin
                    // Link has taken the byte; fetch the one after it
                    n.rdAddr = s.rdAddr + ADDR_STEP;
                    n.fetch[0] = 1'b1;
                    n.st = ST_READ;
                end
                ST_DATA: begin
                    // Later bytes overwrite earlier ones in the same column
                    n.pbuf[s.col] = rxByte;
                    n.mask[s.col] = 1'b1;
                    n.col = s.col + COL_STEP;
                    n.gotData = 1'b1;
                end
                default: begin
                    n.st = s.st;
                end
            endcase
        end
        // Offer the status byte in opcode and hold states unless a read is in flight
        if (s.fetch[1]) begin
            n.hold = rdData;
        end else if ((n.st == ST_OPCODE) || (n.st == ST_HOLD)) begin
            n.hold = status;
        end
        // Select rise completes the frame
        if (frameEnd) begin
            n.st = ST_OPCODE;
            if (!midAbort) begin
                if (s.st == ST_DATA && s.gotData) begin
                    n.op = OP_PROG;
                    n.opIdx = {n.addr[ADDR_W-1:PAGE_W], COL_ZERO};
                end else if (s.st == ST_HOLD) begin
                    case (n.cmd)
                        CMD_ARM: n.latch = 1'b1;
                        CMD_DISARM: n.latch = 1'b0;
                        CMD_SLEEP: begin
                            n.sleep = 1'b1;
                            n.latch = 1'b0;
                        end
                        CMD_PAGE_CLEAR: begin
                            n.op = OP_PAGE;
                            n.opIdx = {n.addr[ADDR_W-1:PAGE_W], COL_ZERO};
                        end
                        CMD_FULL_CLEAR_A, CMD_FULL_CLEAR_B: begin
                            n.op = OP_CHIP;
                            n.opIdx = ADDR_ZERO;
                        end
                        default: n.op = n.op;
                    endcase
                end
            end
        end
    end

    // System state register
    always_ff @(posedge sysClk or negedge resetN) begin
        if (!resetN) begin
            s <= '{st: ST_OPCODE, op: OP_NONE, selHigh: 1'b1, default: '0};
        end else begin
            s <= n;
        end
    end

    assign holdByte = s.hold; // Quasi-static across each byte
    assign busyFlag = (s.op != OP_NONE);
    assign enableLatch = s.latch;
    assign sleeping = s.sleep;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------

    sequence seq_op_ends;
        (s.op != OP_NONE) && opDone;
    endsequence

    sequence seq_read_step;
        byteEv && (s.st == ST_READ);
    endsequence

    a_latch_after_op: assert property (@(posedge sysClk) disable iff (!resetN)
        seq_op_ends |=> !s.latch && !busyFlag)
        else $error("latch or busy left set after operation");

    a_busy_chip_span: assert property (@(posedge sysClk) disable iff (!resetN)
        $rose(busyFlag) && (s.op == OP_CHIP) |-> busyFlag [*8])
        else $error("full clear busy too short");

    a_prog_needs_arm: assert property (@(posedge sysClk) disable iff (!resetN)
        $rose(busyFlag) |-> $past(s.latch))
        else $error("operation started without latch");

    a_sleep_blocks_op: assert property (@(posedge sysClk) disable iff (!resetN)
        s.sleep && !busyFlag |=> !busyFlag)
        else $error("operation started while asleep");

    a_wake_timer_load: assert property (@(posedge sysClk) disable iff (!resetN)
        byteEv && s.sleep && (s.st == ST_OPCODE) && (rxByte == CMD_WAKE)
        |=> !s.sleep && (s.wakeCnt == WAKE_CNT_W'(WAKE_CYCLES)))
        else $error("wake not started on opcode");

    a_busy_ignores: assert property (@(posedge sysClk) disable iff (!resetN)
        byteEv && busyFlag && (s.st == ST_OPCODE) && (rxByte != CMD_FLAG_READ) && !frameEnd
        |=> s.st == ST_SKIP)
        else $error("command accepted while busy");

    a_col_wraps: assert property (@(posedge sysClk) disable iff (!resetN)
        byteEv && (s.st == ST_DATA) && (s.col == COL_LAST) |=> s.col == COL_ZERO)
        else $error("page column did not wrap");

    a_read_prefetch: assert property (@(posedge sysClk) disable iff (!resetN)
        seq_read_step |=> (s.rdAddr == $past(s.rdAddr) + ADDR_STEP) ##2 (s.hold == $past(rdData)))
        else $error("read prefetch wrong");

    a_abort_keeps: assert property (@(posedge sysClk) disable iff (!resetN)
        frameEnd && midAbort && !busyFlag |=> s.latch == $past(s.latch))
        else $error("aborted frame changed latch");

    a_link_byte_tog: assert property (@(posedge shiftClock) disable iff (frameIdle)
        lf.bitCnt == BIT_LAST |=> lk.byteTog != $past(lk.byteTog))
        else $error("byte boundary not signalled");
endmodule // smc_engine
`default_nettype wire

/* File: smc_pkg.sv */
`default_nettype none
// -----------------------------------------------------------------
// Shared constants for the serial memory command engine
// -----------------------------------------------------------------
package smc_pkg;
    // Opcodes as shifted in, most significant bit first
    localparam logic [7:0] CMD_QUICK_READ = 8'h0B;
    localparam logic [7:0] CMD_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_PAGE_CLEAR = 8'h42;
    localparam logic [7:0] CMD_ARM = 8'h06;
    localparam logic [7:0] CMD_DISARM = 8'h04;
    localparam logic [7:0] CMD_FLAG_READ = 8'h05;
    localparam logic [7:0] CMD_FULL_CLEAR_A = 8'h60;
    localparam logic [7:0] CMD_FULL_CLEAR_B = 8'hC7;
    localparam logic [7:0] CMD_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    // Array geometry
    localparam int ADDR_W = 12;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int MEM_DEPTH = 4096;
    localparam int ADDR_HI_W = ADDR_W - 8;
    localparam logic [PAGE_W-1:0] COL_ZERO = 5'h00;
    localparam logic [PAGE_W-1:0] COL_LAST = 5'h1F;
    localparam logic [PAGE_W-1:0] COL_STEP = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 12'hFFF;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 12'h001;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Status byte layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LATCH_BIT = 1;
    localparam logic [7:0] STATUS_ZERO = 8'h00;
    // Bit counter of the link
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Idle levels of the crossing bits: {mid-byte, byte toggle, select}
    localparam logic [2:0] SYNC_IDLE = 3'h1;
    // Wake delay, rounded up to whole system clocks
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_DELAY_US = 75;
    localparam int WAKE_CYCLES = (WAKE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 14;
    localparam logic [WAKE_CNT_W-1:0] WAKE_ONE = 14'h0001;
    // Frame decoder states
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000, ST_ADDR_HI = 3'b001, ST_ADDR_LO = 3'b010, ST_DUMMY = 3'b011,
        ST_READ = 3'b100, ST_DATA = 3'b101, ST_HOLD = 3'b110, ST_SKIP = 3'b111
    } smc_frame_t;
    // Self-timed array operations
    typedef enum logic [1:0] {
        OP_NONE = 2'b00, OP_PROG = 2'b01, OP_PAGE = 2'b10, OP_CHIP = 2'b11
    } smc_op_t;
endpackage
`default_nettype wire

/* File: smc_sync3.sv */
`default_nettype none
// -----------------------------------------------------------------
// Three-stage synchroniser for three unrelated bits
// -----------------------------------------------------------------
module smc_sync3 (
    // Clock and reset
    input wire logic sysClk,
    input wire logic resetN,
    // Asynchronous bits
    input wire logic [2:0] asyncIn,
    // Second and third stages
    output logic [2:0] syncMid,
    output logic [2:0] syncOut
);
    import smc_pkg::*;
    // Stage registers; stage one feeds stage two only
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } smc_sync_t;
    smc_sync_t s, next_s;

    // Shift one stage per clock
    always_comb begin
        next_s.s1 = asyncIn;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
    end

    // Stages reset to the idle levels of the link; a toggle stage reset
    // away from its source would fake a byte right after reset
    always_ff @(posedge sysClk or negedge resetN) begin
        if (!resetN) begin
            s <= '{s1: SYNC_IDLE, s2: SYNC_IDLE, s3: SYNC_IDLE};
        end else begin
            s <= next_s;
        end
    end

    assign syncMid = s.s2;
    assign syncOut = s.s3;
endmodule // smc_sync3
`default_nettype wire

/* File: smc_mem.sv */
`default_nettype none
// -----------------------------------------------------------------
// Byte array with one write and one registered read port
// -----------------------------------------------------------------
module smc_mem (
    // Clock
    input wire logic sysClk,
    // Write port
    input wire logic arm_cmd,
    input wire logic [smc_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [7:0] wrData,
    // Read port, one cycle latency
    input wire logic [smc_pkg::ADDR_W-1:0] rdAddr,
    output logic [7:0] rdData
);
    import smc_pkg::*;

    // Storage has no reset, like the real cells
    logic [7:0] cells [MEM_DEPTH];

    // Read first: a collision returns the old word
    always_ff @(posedge sysClk) begin
        if (arm_cmd) begin
            cells[wrAddr] <= wrData;
        end
        rdData <= cells[rdAddr];
    end
endmodule // smc_mem
`default_nettype wire

/* File: smc_host_model.sv */
`default_nettype none
// -----------------------------------------------------------------
// Host side of the serial link, clock idles low
// -----------------------------------------------------------------
module smc_host_model #(
    parameter int HALF_NS = 40
) (
    // Link pins driven by the host
    output logic shiftClock,
    output logic selectN,
    output logic serialIn,
    // Link pin driven by the device
    input wire logic serialOut
);
    timeunit 1ns;
    timeprecision 1ps;
    // Link parked: no clock outside frames
    initial begin
        shiftClock = 1'b0;
        serialIn = 1'b0;
        // Select settles after the reset edge, so the frame clear sees an edge
        #2;
        selectN = 1'b1;
    end
    // Select falls, first bit goes out on the next rise
    task automatic open_frame();
        selectN = 1'b0;
        #HALF_NS;
    endtask
    // Shift n bits MSB first, capture the reply on each rise
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i >= 8 - n; i--) begin
            serialIn = tx[i];
            #HALF_NS;
            shiftClock = 1'b1;
            rx[i] = serialOut;
            #HALF_NS;
            shiftClock = 1'b0;
        end
    endtask
    // Rise inside the low phase after the last bit, then a gap
    task automatic close_frame();
        #10;
        selectN = 1'b1;
        // Released data line shows no stale level
        serialIn = ~serialIn;
        #(3 * HALF_NS);
    endtask
endmodule // smc_host_model
`default_nettype wire

/* File: test_serial_memory_command_engine.sv */
`default_nettype none
module test_serial_memory_command_engine;
    timeunit 1ns;
    timeprecision 1ps;
    import smc_pkg::*;
    // -----------------------------------------------------------------
    // Clock, reset, link wires
    // -----------------------------------------------------------------
    localparam int WAKE = 200; // Short wake delay, still longer than one frame
    logic sysClk = 1'b0;
    logic resetN = 1'b1; // Dropped just after start so reset sees a real edge
    logic shiftClock, selectN, serialIn, serialOut, serialOutEn, busyFlag, enableLatch, sleeping;
    logic [7:0] img [0:4095]; // Expected array contents
    logic [7:0] rxq [$]; // Bytes seen during the last frame
    int fails = 0;
    int cmpCount = 0;
    always #4 sysClk = ~sysClk;
    // Link clock of 64 ns, four system clocks per half period
    smc_host_model #(.HALF_NS(32)) host (.shiftClock(shiftClock), .selectN(selectN), .serialIn(serialIn),
        .serialOut(serialOut));
    smc_engine #(.WAKE_CYCLES(WAKE)) DUT (.sysClk(sysClk), .resetN(resetN), .shiftClock(shiftClock),
        .selectN(selectN), .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .busyFlag(busyFlag), .enableLatch(enableLatch), .sleeping(sleeping));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmpCount++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Whole bytes in one frame
    task automatic frame(input logic [7:0] txq [$]);
        logic [7:0] rx;
        rxq = {};
        host.open_frame();
        check("serialOutEn", 8'h01, {7'h00, serialOutEn});
        foreach (txq[i]) begin
            host.shift(txq[i], 8, rx);
            rxq.push_back(rx);
        end
        host.close_frame();
    endtask
    // Bounded wait for the array cycle to end
    task automatic wait_idle();
        int n;
        n = 0;
        while (busyFlag !== 1'b0 && n < 6000) begin
            @(negedge sysClk);
            n++;
        end
        check("busyFlag idle", 8'h00, {7'h00, busyFlag});
    endtask
    // Arm in its own frame, run a write-type frame, see it finish
    task automatic armed(input logic [7:0] txq [$]);
        frame('{CMD_ARM});
        check("enableLatch armed", 8'h01, {7'h00, enableLatch});
        frame(txq);
        check("busyFlag", 8'h01, {7'h00, busyFlag});
        wait_idle();
        check("enableLatch done", 8'h00, {7'h00, enableLatch});
    endtask
    // Quick read of n bytes from a, compared with the image
    task automatic read_check(input logic [11:0] a, input int n);
        logic [7:0] tq [$];
        logic [11:0] ai;
        tq = '{CMD_QUICK_READ, {4'h0, a[11:8]}, a[7:0], 8'($urandom)};
        repeat (n) tq.push_back(8'($urandom));
        frame(tq);
        for (int i = 0; i < n; i++) begin
            ai = a + 12'(i);
            check("readByte", img[ai], rxq[4 + i]);
        end
    endtask
    // -----------------------------------------------------------------
    // Watchdog, about two and a half times the expected run of some 240 microseconds
    // -----------------------------------------------------------------
    initial begin
        #600_000;
        fails++;
        $display("BAD watchdog expected end seen hang");
        stop_test();
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        logic [7:0] tq [$];
        logic [11:0] base;
        logic [4:0] col;
        logic [7:0] junk;
        int n;
        void'($urandom(32'h506108ab));
        #1 resetN = 1'b0;
        repeat (10) @(negedge sysClk);
        resetN = 1'b1;
        repeat (6) @(negedge sysClk);
        check("resetState", 8'h00, {5'h00, busyFlag, enableLatch, sleeping});
        // Both full clear opcodes; status and a stray program while busy
        for (int k = 0; k < 2; k++) begin
            frame('{CMD_ARM});
            frame('{(k == 0) ? CMD_FULL_CLEAR_A : CMD_FULL_CLEAR_B});
            frame('{CMD_FLAG_READ, 8'h00});
            check("statusBusy", 8'h03, rxq[1]);
            frame('{CMD_PROGRAM, 8'h00, 8'h40, 8'h5A});
            wait_idle();
            check("enableLatch clear", 8'h00, {7'h00, enableLatch});
        end
        foreach (img[i]) img[i] = ERASED_BYTE;
        frame('{CMD_FLAG_READ, 8'h00});
        check("statusIdle", 8'h00, rxq[1]);
        // Unarmed program is dropped
        frame('{CMD_PROGRAM, 8'h00, 8'h41, 8'h77});
        check("busyUnarmed", 8'h00, {7'h00, busyFlag});
        read_check(12'h040, 3);
        $display("test clear done");
        // Random page programs, one of a single byte and one over-long among them
        for (int k = 0; k < 4; k++) begin
            base = {7'($urandom_range(127, 0)), 5'h00};
            col = 5'($urandom);
            n = (k == 0) ? 1 : (k == 1) ? 40 : $urandom_range(31, 2);
            tq = '{CMD_PROGRAM, {4'h0, base[11:8]}, {base[7:5], col}};
            for (int i = 0; i < n; i++) begin
                tq.push_back(8'($urandom));
                img[{base[11:5], 5'(col + 5'(i))}] = tq[3 + i];
            end
            armed(tq);
            read_check(base, 32);
        end
        $display("test program done");
        // Read across the top address
        armed('{CMD_PROGRAM, 8'h0F, 8'hFF, 8'hA5});
        armed('{CMD_PROGRAM, 8'h00, 8'h00, 8'h3C});
        img[12'hFFF] = 8'hA5;
        img[12'h000] = 8'h3C;
        read_check(12'hFFF, 2);
        // Page clear with a non-zero column
        armed('{CMD_PAGE_CLEAR, {4'h0, base[11:8]}, {base[7:5], 5'h13}});
        for (int i = 0; i < 32; i++) img[base + 12'(i)] = ERASED_BYTE;
        read_check(base, 32);
        $display("test wrap and page clear done");
        // Aborted disarm keeps the latch, a whole one clears it
        frame('{CMD_ARM});
        host.open_frame();
        host.shift(CMD_DISARM, 4, junk);
        host.close_frame();
        check("latchAbort", 8'h01, {7'h00, enableLatch});
        frame('{CMD_DISARM});
        check("latchDisarm", 8'h00, {7'h00, enableLatch});
        // Sleep, ignored arm, wake and delayed acceptance
        frame('{CMD_ARM});
        frame('{CMD_SLEEP});
        check("sleepState", 8'h02, {6'h00, sleeping, enableLatch});
        frame('{CMD_ARM});
        check("latchAsleep", 8'h00, {7'h00, enableLatch});
        frame('{CMD_WAKE});
        check("sleepWake", 8'h00, {7'h00, sleeping});
        frame('{CMD_ARM});
        check("latchWaking", 8'h00, {7'h00, enableLatch});
        repeat (WAKE + 8) @(negedge sysClk);
        frame('{CMD_ARM});
        check("latchWoken", 8'h01, {7'h00, enableLatch});
        $display("test sleep done");
        stop_test();
    end
endmodule // test_serial_memory_command_engine
`default_nettype wire
